// File: pkg/srpm_pkg.sv
// Constants and types for the refresh and low-power control block.
// Assumes a single 25 MHz system clock; all figures are derived here.
package srpm_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS             = 40;          // System clock period
    localparam int REFRESH_CYCLE_TIME_NS     = 70;          // Refresh cycle time, plain default
    // Least time: round up to whole cycles
    localparam int REFRESH_CYCLE_CLKS        = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_WINDOW_MS         = 64;          // Refresh window
    localparam int ROW_COUNT                 = 4096;        // Rows per refresh window
    // Longest time between self-refresh cycles: round down
    localparam int SREF_TICK_CLKS            = (REFRESH_WINDOW_MS * 1000000 / ROW_COUNT) / CLK_PERIOD_NS;
    localparam int SREF_EXIT_CLKS            = 2;           // Least stay in exit recovery

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int ROW_W                     = 12;          // Refresh row counter width
    localparam int TMR_W                     = 9;           // Holds SREF_TICK_CLKS
    localparam logic [ROW_W-1:0] ROW_RESET   = 12'hfff;     // First refresh lands on row zero
    localparam logic [TMR_W-1:0] TMR_RESET   = 9'h000;

    // ------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_AUTO_REF,
        ST_SELF_REF,
        ST_SREF_EXIT,
        ST_POWER_DOWN
    } srpm_state_t;

endpackage

// File: pkg/srpm_refresh_if.sv
// Link between the mode controller and the refresh row counter.
// Assumes both ends share sys_clk.
interface srpm_refresh_if import srpm_pkg::*; ();

    logic             start;   // Begin one refresh cycle
    logic             busy;    // Refresh cycle running
    logic [ROW_W-1:0] row;     // Row of the current or last refresh

    modport ctrl (output start, input busy, input row);
    modport cnt  (input start, output busy, output row);

endinterface

// File: hw/srpm_row_counter.sv
// Internal refresh row counter and refresh cycle timer.
// Assumes start is only acted on while no refresh is running.
module srpm_row_counter import srpm_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Controller side
    srpm_refresh_if.cnt rif
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [ROW_W-1:0] row_ff;        // Row being refreshed
    logic [ROW_W-1:0] nxt_row;
    logic [TMR_W-1:0] busy_cnt_ff;   // Cycles left in refresh
    logic [TMR_W-1:0] nxt_busy_cnt;

    assign rif.row  = row_ff;
    assign rif.busy = (busy_cnt_ff != TMR_RESET);

    // Next row and busy time; address pins never feed this
    always_comb begin
        nxt_row      = row_ff;
        nxt_busy_cnt = busy_cnt_ff;
        if (rif.start && !rif.busy) begin
            nxt_row      = row_ff + 12'h001;
            nxt_busy_cnt = TMR_W'(REFRESH_CYCLE_CLKS);
        end else if (rif.busy) begin
            nxt_busy_cnt = busy_cnt_ff - 9'h001;
        end
    end

    // Register only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            row_ff      <= ROW_RESET;
            busy_cnt_ff <= TMR_RESET;
        end else begin
            row_ff      <= nxt_row;
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_row_step_internal: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rif.start && !rif.busy |=> row_ff == $past(row_ff) + 12'h001 && rif.busy)
        else $error("refresh row did not advance by one");

endmodule

// File: hw/srpm_core.sv
// Refresh, self refresh, power-down and clock suspend control of the memory.
// Assumes pins are synchronous to sys_clk and that the core reports open
// banks and running column bursts.
//
// Function
// - Refresh row comes from internal counter
// - In self refresh only gate input matters
// - Self refresh runs internally timed refresh cycles
// - Gate low with idle enters power-down
// - Power-down disables buffers except gate input
// - Idle command with gate high ends power-down
// - Gate low in burst enters clock suspend
// - Each low gate edge skips next internal edge
// - Gate high resumes on following edge
module srpm_core import srpm_pkg::*; (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // Command pins
    input  wire logic             cke,
    input  wire logic             cs_n,
    input  wire logic             ras_n,
    input  wire logic             cas_n,
    input  wire logic             we_n,
    input  wire logic [ROW_W-1:0] addr,
    // Core status
    input  wire logic             any_bank_open,
    input  wire logic             burst_active,
    // Refresh outputs
    output logic      [ROW_W-1:0] refresh_row,
    output logic                  refresh_pulse,
    output logic                  refresh_busy,
    // Mode outputs
    output logic                  in_self_refresh,
    output logic                  in_exit_recovery,
    output logic                  in_pdn_precharge,
    output logic                  in_pdn_active,
    output logic                  int_clk_en,
    output logic                  cmd_enable,
    output logic                  buf_enable,
    output logic                  dq_hold
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    srpm_refresh_if rif ();              // Link to the row counter

    srpm_state_t      state_ff;          // Operating mode
    srpm_state_t      nxt_state;
    logic [TMR_W-1:0] tmr_ff;            // Self refresh tick or exit count
    logic [TMR_W-1:0] nxt_tmr;
    logic             pdn_act_ff;        // Power-down entered with a row open
    logic             nxt_pdn_act;
    logic             clk_en_ff;         // Internal clock edge allowed
    logic             nxt_clk_en;
    logic             start;             // Refresh start request
    logic             is_nop;            // Inhibit or no-operation
    logic             is_ref;            // Refresh command encoding
    logic             addr_unused;       // Address is a don't-care here

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign is_nop      = cs_n | (ras_n & cas_n & we_n);
    assign is_ref      = !cs_n && !ras_n && !cas_n && we_n;
    // Address never reaches refresh logic; row is internal
    assign addr_unused = ^addr;

    // ------------------------------------------------------------
    // Row counter
    // ------------------------------------------------------------
    srpm_row_counter u_row_counter (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .rif     (rif.cnt)
    );

    assign rif.start = start;

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    // Next mode, timers and suspend; idle only acts when not suspended
    always_comb begin
        nxt_state   = state_ff;
        nxt_tmr     = tmr_ff;
        nxt_pdn_act = pdn_act_ff;
        nxt_clk_en  = 1'b1;
        start       = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // Suspend holds while gate stays low, from a burst onward
                if (!cke && (burst_active || !clk_en_ff)) begin
                    nxt_clk_en = 1'b0;
                end
                // Gate sampled high lifts suspend on the next edge
                if (clk_en_ff && !rif.busy) begin
                    if (is_ref && !any_bank_open) begin
                        start = 1'b1;
                        if (cke) begin
                            nxt_state = ST_AUTO_REF;
                        end else begin
                            nxt_state = ST_SELF_REF;
                            nxt_tmr   = TMR_W'(SREF_TICK_CLKS - 1);
                        end
                    end else if (!cke && is_nop && !burst_active) begin
                        nxt_state   = ST_POWER_DOWN;
                        nxt_pdn_act = any_bank_open;
                    end
                end
            end
            ST_AUTO_REF: begin
                // Refresh runs to its end; other commands have no effect
                if (!rif.busy) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SELF_REF: begin
                // Only the gate input is looked at here
                if (cke) begin
                    nxt_state = ST_SREF_EXIT;
                    nxt_tmr   = TMR_W'(SREF_EXIT_CLKS - 1);
                end else if (tmr_ff == TMR_RESET) begin
                    // Internal timebase; a refresh still running delays the tick
                    if (!rif.busy) begin
                        start   = 1'b1;
                        nxt_tmr = TMR_W'(SREF_TICK_CLKS - 1);
                    end
                end else begin
                    nxt_tmr = tmr_ff - 9'h001;
                end
            end
            ST_SREF_EXIT: begin
                // Let any refresh in flight finish before taking commands
                if (tmr_ff != TMR_RESET) begin
                    nxt_tmr = tmr_ff - 9'h001;
                end else if (!rif.busy) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_POWER_DOWN: begin
                // Only an idle command with the gate high wakes it
                if (cke && is_nop) begin
                    nxt_state   = ST_IDLE;
                    nxt_pdn_act = 1'b0;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Register only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= ST_IDLE;
            tmr_ff     <= TMR_RESET;
            pdn_act_ff <= 1'b0;
            clk_en_ff  <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            tmr_ff     <= nxt_tmr;
            pdn_act_ff <= nxt_pdn_act;
            clk_en_ff  <= nxt_clk_en;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign refresh_row      = rif.row;
    assign refresh_pulse    = start;
    assign refresh_busy     = rif.busy;
    assign in_self_refresh  = (state_ff == ST_SELF_REF);
    assign in_exit_recovery = (state_ff == ST_SREF_EXIT);
    assign in_pdn_precharge = (state_ff == ST_POWER_DOWN) && !pdn_act_ff;
    assign in_pdn_active    = (state_ff == ST_POWER_DOWN) && pdn_act_ff;
    assign int_clk_en       = clk_en_ff;
    // Commands only reach the core on a live internal edge in idle
    assign cmd_enable       = (state_ff == ST_IDLE) && clk_en_ff;
    // Buffers off in power-down and self refresh to save standby power
    assign buf_enable       = (state_ff != ST_POWER_DOWN) && (state_ff != ST_SELF_REF);
    // Suspended output data stays on the pins
    assign dq_hold          = !clk_en_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_sref_exit_start;
        state_ff == ST_SELF_REF && cke;
    endsequence

    sequence s_exit_recovery;
        in_exit_recovery [*2] ##1 !in_self_refresh;
    endsequence

    a_sref_exit_steps: assert property (s_sref_exit_start |=> s_exit_recovery)
        else $error("self refresh exit recovery shorter than two clocks");

    a_sref_hold_low: assert property (state_ff == ST_SELF_REF && !cke |=> state_ff == ST_SELF_REF)
        else $error("self refresh left while gate low");

    a_sref_tick_start: assert property (
        state_ff == ST_SELF_REF && !cke && tmr_ff == TMR_RESET && !rif.busy |-> refresh_pulse ##1 refresh_busy)
        else $error("self refresh tick did not start a refresh");

    a_pdn_entry_kind: assert property (
        state_ff == ST_IDLE && clk_en_ff && !rif.busy && !cke && is_nop && !burst_active
        |=> state_ff == ST_POWER_DOWN && in_pdn_active == $past(any_bank_open))
        else $error("power-down entry or kind wrong");

    a_pdn_buffers_off: assert property (state_ff == ST_POWER_DOWN |-> !buf_enable && !cmd_enable)
        else $error("buffers active in power-down");

    a_pdn_exit_edge: assert property (
        state_ff == ST_POWER_DOWN |=> (state_ff == ST_IDLE) == $past(cke && is_nop))
        else $error("power-down exit on wrong edge");

    a_susp_entry_burst: assert property (
        state_ff == ST_IDLE && burst_active && !cke |=> !int_clk_en && dq_hold && !cmd_enable)
        else $error("clock suspend not entered");

    a_susp_exit_edge: assert property (!int_clk_en && cke |=> int_clk_en)
        else $error("clock suspend did not end after gate high");

endmodule

// File: tb/srpm_ctrl_model.sv
// Memory controller model: drives the command pins and the clock gate.
// Assumes the bench calls put just after a rising edge of sys_clk.
module srpm_ctrl_model import srpm_pkg::*; (
    // Command pins
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [ROW_W-1:0] addr
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Pin state
    // ------------------------------------------------------------
    // Start from command inhibit (chip select high) with the gate on, so reset sees no command
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
        addr = 12'h5a5;
    end

    // One command per edge. The caller closes banks and waits out recovery
    // before a refresh, and sends idle cycles while a refresh runs
    task automatic put(input logic rf, input logic k, input logic [ROW_W-1:0] a);
        // Gate low with refresh enters self refresh, held low until exit
        // Gate only rises on a running clock, then NOPs follow
        cke = k;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = rf ? 3'h1 : 3'h7;
        // Address is unused on NOP; flip it so a stale value never looks held
        addr = rf ? a : ~addr;
    endtask
endmodule

// File: tb/srpm_core_test.sv
// Bench for the refresh and low-power control block.
// Assumes the controller model drives the pins and the bench the core status.
module srpm_core_test import srpm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals and expected flag patterns
    // ------------------------------------------------------------
    // Order: sref, exit, pdn_pre, pdn_act, clk_en, cmd_en, buf_en, dq_hold
    localparam logic [7:0] F_IDLE = 8'h0e, F_BUSY = 8'h0a, F_SREF = 8'h88;
    localparam logic [7:0] F_PDP = 8'h28, F_PDA = 8'h18, F_SUSP = 8'h03;
    logic             sys_clk, arst_n, cke, cs_n, ras_n, cas_n, we_n;
    logic [ROW_W-1:0] addr, refresh_row;
    logic             any_bank_open, burst_active, refresh_pulse, refresh_busy;
    logic             in_self_refresh, in_exit_recovery, in_pdn_precharge, in_pdn_active;
    logic             int_clk_en, cmd_enable, buf_enable, dq_hold;
    logic [31:0]      seed;      // Random state
    int               err_count; // Mismatches
    int               checks;    // Comparisons
    int               n_ref;     // Refreshes the reference model expects
    int               pulses;    // Refresh pulses seen
    int               i, n, t;

    srpm_ctrl_model ctl (.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr));
    srpm_core dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .addr(addr), .any_bank_open(any_bank_open),
        .burst_active(burst_active), .refresh_row(refresh_row), .refresh_pulse(refresh_pulse),
        .refresh_busy(refresh_busy), .in_self_refresh(in_self_refresh),
        .in_exit_recovery(in_exit_recovery), .in_pdn_precharge(in_pdn_precharge),
        .in_pdn_active(in_pdn_active), .int_clk_en(int_clk_en), .cmd_enable(cmd_enable),
        .buf_enable(buf_enable), .dq_hold(dq_hold));

    // 25 MHz clock
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // Count every refresh start; a refused command must add none
    always @(negedge sys_clk) begin
        if (refresh_pulse === 1'b1) begin
            pulses++;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic [7:0] flags();
        return {in_self_refresh, in_exit_recovery, in_pdn_precharge, in_pdn_active,
                int_clk_en, cmd_enable, buf_enable, dq_hold};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One cycle, c = {refresh, gate, bank open, burst}: drive after the edge,
    // then stop mid-cycle where outputs have settled
    task automatic cyc(input logic [3:0] c);
        @(posedge sys_clk);
        #1;
        seed = xs(seed);
        any_bank_open = c[1];
        burst_active = c[0];
        ctl.put(c[3], c[2], seed[ROW_W-1:0]);
        @(negedge sys_clk);
    endtask

    // Reference row counter steps once per refresh, wrapping at the row width
    task automatic took();
        n_ref++;
        chk(refresh_row, (n_ref - 1) & 32'h0000_0fff);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'h0000_cd4f;
        arst_n = 1'b0;
        any_bank_open = 1'b0;
        burst_active = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        @(negedge sys_clk);
        chk({refresh_busy, flags()}, {1'b0, F_IDLE});
        // Row counter sits one below zero so the first refresh hits row zero
        chk(refresh_row, ROW_RESET);
        n_ref = 0;
        // Back-to-back auto refresh at the fastest spacing, random address
        for (i = 0; i < 3; i++) begin
            cyc(4'hc);
            chk(refresh_pulse, 1);
            cyc(4'h4);
            took();
            chk({refresh_busy, flags()}, {1'b1, F_BUSY});
            cyc(4'h4);
            chk(refresh_busy, 1);
            cyc(4'h4);
            chk(refresh_busy, 0);
        end
        // An open bank makes the refresh command void
        cyc(4'h4);
        cyc(4'he);
        chk(refresh_pulse, 0);
        // Self refresh with random ignored commands while the gate stays low
        cyc(4'h8);
        chk(refresh_pulse, 1);
        cyc(4'h0);
        took();
        chk(flags(), F_SREF);
        t = 1;
        while (refresh_pulse !== 1'b1) begin
            cyc({seed[0], 1'b0, seed[1], 1'b0});
            t++;
            if (t > 400) begin
                err_count++;
                tally_and_finish();
            end
        end
        chk(t, SREF_TICK_CLKS);
        cyc(4'h0);
        took();
        // Let the internal refresh finish, then raise the gate
        repeat (2) cyc(4'h0);
        cyc(4'h4);
        cyc(4'h4);
        chk(flags() & 8'hc0, 8'h40);
        cyc(4'h4);
        chk(in_exit_recovery, 1);
        cyc(4'h4);
        chk(flags(), F_IDLE);
        // Auto refresh carries on from the shared row counter
        cyc(4'hc);
        cyc(4'h4);
        took();
        repeat (2) cyc(4'h4);
        // Precharge then active power-down; a non-idle command does not wake it
        for (i = 0; i < 2; i++) begin
            cyc({2'h0, i[0], 1'b0});
            cyc({2'h3, i[0], 1'b0});
            chk(flags(), i ? F_PDA : F_PDP);
            chk(refresh_pulse, 0);
            cyc(4'h4);
            chk(flags(), i ? F_PDA : F_PDP);
            cyc(4'h4);
            chk(flags(), F_IDLE);
        end
        // Clock suspend for a random number of low-gate edges
        n = 1 + int'(seed[1:0]);
        cyc(4'h1);
        for (i = 0; i < n; i++) begin
            cyc(4'h9);
            chk({refresh_pulse, flags()}, {1'b0, F_SUSP});
        end
        cyc(4'h5);
        chk(flags(), F_SUSP);
        cyc(4'h5);
        chk(flags(), F_IDLE);
        chk(pulses, n_ref);
        tally_and_finish();
    end
endmodule
